/* rtl/pst_pkg.sv */
`default_nettype none
package pst_pkg;
  // ------------------------------------------------------------
  // processor address decode
  // ------------------------------------------------------------
  localparam int unsigned PA_W = 40;
  localparam logic [39:0] SMEM_LO = 40'h80_0000_0000;
  localparam logic [39:0] SMEM_HI = 40'h80_07DF_FFFF;
  localparam logic [39:0] SIO_LO = 40'h85_8000_0000;
  localparam logic [39:0] SIO_HI = 40'h85_80FF_FFFF;
  localparam logic [39:0] CFG_LO = 40'h87_0000_0000;
  localparam logic [39:0] CFG_HI = 40'h87_1FFF_FFFF;
  localparam logic [4:0] SIO_TAG = 5'h16;
  localparam int unsigned SIO_TAG_MSB = 34;
  localparam int unsigned SIO_TAG_LSB = 30;

  // ------------------------------------------------------------
  // sparse field positions
  // ------------------------------------------------------------
  localparam int unsigned LEN_MSB = 4;
  localparam int unsigned LEN_LSB = 3;
  localparam int unsigned OFS_MSB = 7;
  localparam int unsigned OFS_LSB = 5;
  localparam int unsigned QW_LSB = 8;
  localparam int unsigned SM_QW_MSB = 30;
  localparam int unsigned SIO_QW_MSB = 29;
  localparam int unsigned CFG_QW_MSB = 28;
  localparam int unsigned REGION_BIT = 26;
  localparam int unsigned HI_LSB = 26;
  localparam int unsigned IO_ZERO_LSB = 25;
  localparam int unsigned W1_LSB = 29;
  localparam int unsigned W2_LSB = 26;
  localparam int unsigned PAGE_LSB = 18;

  // ------------------------------------------------------------
  // pci commands and configuration types
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [1:0] CFG_TYPE1 = 2'h1;
  localparam logic [1:0] CFG_TYPE_RST = 2'h0;
  localparam logic [3:0] LEN_QUAD = 4'h8;

  typedef enum logic [1:0] {
    PST_IDLE = 2'b01,
    PST_BUSY = 2'b10
  } pst_state_e;
endpackage
`default_nettype wire

/* rtl/pst_cfg_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module pst_cfg_sel
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // selector load
  input wire logic load,
  input wire logic [1:0] wdata,
  // held selector
  output logic [1:0] sel
);
  logic [1:0] next_sel;

  // ------------------------------------------------------------
  // selector holding register
  // ------------------------------------------------------------
  // value changes only on a load
  always_comb
  begin
    next_sel = sel;
    if (load)
    begin
      next_sel = wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel <= pst_pkg::CFG_TYPE_RST;
    end
    else
    begin
      sel <= next_sel;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_sel_hold;
    @(posedge clk_sys) disable iff (!rst_b)
    !load |=> sel == $past(sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selector changed without load");

  property p_sel_load;
    @(posedge clk_sys) disable iff (!rst_b)
    load |=> sel == $past(wdata);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("selector load lost");
endmodule
`default_nettype wire

/* rtl/pst_translator.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sparse memory length, byte enables and ad 2..0 come from address bits 7..3.
// - sparse memory address bits 30..8 drive pci ad 25..3.
// - sparse memory ad 31..26 from extension value or fixed 000001, by region.
// - sparse memory decoded from 80.0000.0000 to 80.07DF.FFFF.
// - second vme window is 64 MB, 256 pages of 256 KB, in sparse memory.
// - second window page uses the map entry of same-index first window page.
// - sparse io read or write gives pci io read or write.
// - sparse io decoded from 85.8000.0000 to 85.80FF.FFFF.
// - sparse io carries address bits 34..30 equal to 10110.
// - sparse io cycles force pci ad 31..25 to zero.
// - sparse io is claimed by negative decode.
// - configuration space 87.0000.0000 to 87.1FFF.FFFF gives config read or write.
// - selector 00 gives type 0 cycle, 01 gives type 1 cycle.
module pst_translator
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // processor request
  input wire logic proc_req_valid,
  output logic proc_req_ready,
  input wire logic proc_req_write,
  input wire logic proc_req_quad,
  input wire logic [39:0] proc_req_addr,
  input wire logic [63:0] proc_req_wdata,
  // processor answer
  output logic proc_rsp_valid,
  output logic proc_rsp_error,
  output logic [63:0] proc_rsp_rdata,
  // control levels
  input wire logic [5:0] memory_high_address_extension,
  input wire logic cfg_type_load,
  input wire logic [1:0] cfg_type_wdata,
  input wire logic fill_error_enable,
  input wire logic [2:0] first_vme_window_base,
  input wire logic [5:0] second_vme_window_base,
  // pci cycle
  output logic pci_cyc_valid,
  input wire logic pci_cyc_ack,
  output logic [3:0] pci_cmd,
  output logic [31:0] pci_addr,
  output logic [3:0] pci_be,
  output logic [3:0] pci_len,
  output logic [1:0] pci_cfg_type,
  output logic pci_neg_decode,
  output logic pci_fill_check,
  output logic [63:0] pci_wdata,
  input wire logic [63:0] pci_rdata,
  // vme map lookup
  output logic sg_hit,
  output logic sg_second_window,
  output logic [10:0] sg_index
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // byte count from the two-bit length code
  function automatic logic [3:0] len_bytes(input logic [1:0] code, input logic quad);
    logic [3:0] n;
    n = {2'b00, code} + 4'h1;
    if (quad && (code == 2'b11))
    begin
      n = pst_pkg::LEN_QUAD;
    end
    return n;
  endfunction

  // byte enables from length and byte offset
  function automatic logic [3:0] byte_en(input logic [1:0] code, input logic [1:0] ofs,
                                         input logic quad);
    logic [3:0] mask;
    logic [6:0] wide;
    mask = 4'hF >> (2'b11 - code);
    wide = {3'b000, mask} << ofs;
    if (quad)
    begin
      wide = 7'h0F;
    end
    return wide[3:0];
  endfunction

  // inclusive range test
  function automatic logic in_range(input logic [39:0] a, input logic [39:0] lo,
                                    input logic [39:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  pst_pkg::pst_state_e state;
  pst_pkg::pst_state_e next_state;
  logic [1:0] cfg_sel;
  logic hit_smem;
  logic hit_sio;
  logic hit_cfg;
  logic accept;
  logic [1:0] len_code;
  logic [2:0] low_ad;
  logic [31:0] next_pci_addr;
  logic [3:0] next_pci_cmd;
  logic [3:0] next_pci_be;
  logic [3:0] next_pci_len;
  logic [1:0] next_pci_cfg_type;
  logic next_pci_neg_decode;
  logic [63:0] next_pci_wdata;
  logic next_sg_hit;
  logic next_sg_second_window;
  logic [10:0] next_sg_index;
  logic next_rsp_valid;
  logic next_rsp_error;
  logic [63:0] next_rsp_rdata;

  // ------------------------------------------------------------
  // configuration type selector
  // ------------------------------------------------------------
  pst_cfg_sel u_cfg_sel
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(cfg_type_load),
    .wdata(cfg_type_wdata),
    .sel(cfg_sel)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // space hits, io also needs its high tag
  assign hit_smem = in_range(proc_req_addr, pst_pkg::SMEM_LO, pst_pkg::SMEM_HI);
  assign hit_sio = in_range(proc_req_addr, pst_pkg::SIO_LO, pst_pkg::SIO_HI)
    && (proc_req_addr[pst_pkg::SIO_TAG_MSB:pst_pkg::SIO_TAG_LSB] == pst_pkg::SIO_TAG);
  assign hit_cfg = in_range(proc_req_addr, pst_pkg::CFG_LO, pst_pkg::CFG_HI);
  assign proc_req_ready = (state == pst_pkg::PST_IDLE);
  assign accept = proc_req_valid && proc_req_ready;
  assign len_code = proc_req_addr[pst_pkg::LEN_MSB:pst_pkg::LEN_LSB];
  assign low_ad = proc_req_addr[pst_pkg::OFS_MSB:pst_pkg::OFS_LSB];
  assign pci_cyc_valid = (state == pst_pkg::PST_BUSY);
  assign pci_fill_check = fill_error_enable;

  // ------------------------------------------------------------
  // translation and sequencing
  // ------------------------------------------------------------
  // build the next pci cycle and the processor answer
  always_comb
  begin
    next_state = state;
    next_pci_addr = pci_addr;
    next_pci_cmd = pci_cmd;
    next_pci_be = pci_be;
    next_pci_len = pci_len;
    next_pci_cfg_type = pci_cfg_type;
    next_pci_neg_decode = pci_neg_decode;
    next_pci_wdata = pci_wdata;
    next_sg_hit = sg_hit;
    next_sg_second_window = sg_second_window;
    next_sg_index = sg_index;
    next_rsp_valid = 1'b0;
    next_rsp_error = 1'b0;
    next_rsp_rdata = proc_rsp_rdata;
    unique case (state)
      pst_pkg::PST_IDLE:
      begin
        if (accept)
        begin
          next_pci_wdata = proc_req_wdata;
          next_pci_len = len_bytes(len_code, proc_req_quad);
          next_pci_be = byte_en(len_code, low_ad[1:0], proc_req_quad);
          next_pci_neg_decode = 1'b0;
          next_sg_hit = 1'b0;
          next_sg_second_window = 1'b0;
          next_sg_index = '0;
          next_pci_cfg_type = cfg_sel;
          if (hit_smem)
          begin
            next_state = pst_pkg::PST_BUSY;
            next_pci_cmd = proc_req_write ? pst_pkg::CMD_MEM_WR : pst_pkg::CMD_MEM_RD;
            next_pci_addr[2:0] = low_ad;
            next_pci_addr[pst_pkg::HI_LSB-1:3] = proc_req_addr[pst_pkg::SM_QW_MSB:pst_pkg::QW_LSB];
            // low region takes the extension, upper region the fixed value 6'h01
            if (!proc_req_addr[pst_pkg::REGION_BIT])
            begin
              next_pci_addr[31:pst_pkg::HI_LSB] = memory_high_address_extension;
            end
            else
            begin
              next_pci_addr[31:pst_pkg::HI_LSB] = 6'h01;
            end
            // second window shares entries 0..255 with the first
            if (next_pci_addr[31:pst_pkg::W2_LSB] == second_vme_window_base)
            begin
              next_sg_hit = 1'b1;
              next_sg_second_window = 1'b1;
              next_sg_index = {3'b000, next_pci_addr[pst_pkg::W2_LSB-1:pst_pkg::PAGE_LSB]};
            end
            else if (next_pci_addr[31:pst_pkg::W1_LSB] == first_vme_window_base)
            begin
              next_sg_hit = 1'b1;
              next_sg_index = next_pci_addr[pst_pkg::W1_LSB-1:pst_pkg::PAGE_LSB];
            end
          end
          else if (hit_sio)
          begin
            next_state = pst_pkg::PST_BUSY;
            next_pci_cmd = proc_req_write ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD;
            next_pci_addr = {7'h00, proc_req_addr[pst_pkg::SIO_QW_MSB:pst_pkg::QW_LSB], low_ad};
            next_pci_neg_decode = 1'b1;
          end
          else if (hit_cfg && ((cfg_sel == pst_pkg::CFG_TYPE0) || (cfg_sel == pst_pkg::CFG_TYPE1)))
          begin
            next_state = pst_pkg::PST_BUSY;
            next_pci_cmd = proc_req_write ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD;
            next_pci_addr = {8'h00, proc_req_addr[pst_pkg::CFG_QW_MSB:pst_pkg::QW_LSB], low_ad};
          end
          else
          begin
            next_rsp_valid = 1'b1; // unmapped or reserved selector
            next_rsp_error = 1'b1;
          end
        end
      end
      pst_pkg::PST_BUSY:
      begin
        if (pci_cyc_ack)
        begin
          next_state = pst_pkg::PST_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp_rdata = pci_rdata;
        end
      end
    endcase
  end

  // register the cycle and the answer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= pst_pkg::PST_IDLE;
      pci_addr <= '0;
      pci_cmd <= '0;
      pci_be <= '0;
      pci_len <= '0;
      pci_cfg_type <= pst_pkg::CFG_TYPE_RST;
      pci_neg_decode <= 1'b0;
      pci_wdata <= '0;
      sg_hit <= 1'b0;
      sg_second_window <= 1'b0;
      sg_index <= '0;
      proc_rsp_valid <= 1'b0;
      proc_rsp_error <= 1'b0;
      proc_rsp_rdata <= '0;
    end
    else
    begin
      state <= next_state;
      pci_addr <= next_pci_addr;
      pci_cmd <= next_pci_cmd;
      pci_be <= next_pci_be;
      pci_len <= next_pci_len;
      pci_cfg_type <= next_pci_cfg_type;
      pci_neg_decode <= next_pci_neg_decode;
      pci_wdata <= next_pci_wdata;
      sg_hit <= next_sg_hit;
      sg_second_window <= next_sg_second_window;
      sg_index <= next_sg_index;
      proc_rsp_valid <= next_rsp_valid;
      proc_rsp_error <= next_rsp_error;
      proc_rsp_rdata <= next_rsp_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_take_smem;
    accept && hit_smem;
  endsequence

  sequence s_take_sio;
    accept && hit_sio;
  endsequence

  property p_smem_low;
    @(posedge clk_sys) disable iff (!rst_b)
    s_take_smem |=> pci_cyc_valid && (pci_addr[2:0] == $past(proc_req_addr[7:5]))
      && (pci_be != 4'h0);
  endproperty
  a_smem_low: assert property (p_smem_low) else $error("sparse low bits wrong");

  property p_smem_qw;
    @(posedge clk_sys) disable iff (!rst_b)
    s_take_smem |=> pci_addr[25:3] == $past(proc_req_addr[30:8]);
  endproperty
  a_smem_qw: assert property (p_smem_qw) else $error("sparse quadword address wrong");

  property p_smem_high;
    @(posedge clk_sys) disable iff (!rst_b)
    s_take_smem ##0 !proc_req_addr[26] |=> pci_addr[31:26] == $past(memory_high_address_extension);
  endproperty
  a_smem_high: assert property (p_smem_high) else $error("extension not used");

  property p_smem_edge;
    @(posedge clk_sys) disable iff (!rst_b)
    accept && (proc_req_addr == 40'h80_07E0_0000) |=> proc_rsp_valid && proc_rsp_error;
  endproperty
  a_smem_edge: assert property (p_smem_edge) else $error("address past sparse memory taken");

  property p_win2;
    @(posedge clk_sys) disable iff (!rst_b)
    pci_cyc_valid && sg_second_window |-> sg_hit && (sg_index == {3'b000, pci_addr[25:18]});
  endproperty
  a_win2: assert property (p_win2) else $error("second window entry wrong");

  property p_io_cmd;
    @(posedge clk_sys) disable iff (!rst_b)
    s_take_sio |=> pci_cmd == ($past(proc_req_write) ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD);
  endproperty
  a_io_cmd: assert property (p_io_cmd) else $error("io command wrong");

  property p_io_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    pci_cyc_valid && pci_neg_decode |-> (pci_addr[31:25] == 7'h00)
      && ((pci_cmd == pst_pkg::CMD_IO_RD) || (pci_cmd == pst_pkg::CMD_IO_WR));
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("io high bits not zero");

  property p_cfg_type;
    @(posedge clk_sys) disable iff (!rst_b)
    accept && hit_cfg && (cfg_sel[1] == 1'b0) |=> pci_cyc_valid
      && (pci_cfg_type == $past(cfg_sel)) && (pci_cmd[3:1] == 3'b101);
  endproperty
  a_cfg_type: assert property (p_cfg_type) else $error("config cycle type wrong");

  sequence s_ack;
    pci_cyc_valid && pci_cyc_ack;
  endsequence

  property p_done;
    @(posedge clk_sys) disable iff (!rst_b)
    s_ack |=> proc_rsp_valid && !proc_rsp_error && !pci_cyc_valid
      && (proc_rsp_rdata == $past(pci_rdata));
  endproperty
  a_done: assert property (p_done) else $error("answer not returned");
endmodule
`default_nettype wire

/* rtl/unused_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* sim/pst_pci_target.sv */
`timescale 1ns/1ps
`default_nettype none
module pst_pci_target
(
  // clock
  input wire logic clk_sys,
  // pci cycle
  input wire logic pci_cyc_valid,
  input wire logic [31:0] pci_addr,
  output logic pci_cyc_ack,
  output logic [63:0] pci_rdata,
  // answer delay in cycles
  input wire logic [3:0] delay
);
  logic [3:0] cnt;

  // ------------------------------------------------------------
  // target answer
  // ------------------------------------------------------------
  // quiet start
  initial
  begin
    pci_cyc_ack = 1'b0;
    pci_rdata = 64'h0000_0000_0000_0000;
    cnt = 4'h0;
  end

  // claims any cycle offered, io included, without address decode
  always @(negedge clk_sys)
  begin
    pci_cyc_ack <= 1'b0;
    pci_rdata <= ~pci_rdata; // data only meaningful at ack
    if (pci_cyc_valid && !pci_cyc_ack)
    begin
      if (cnt >= delay)
      begin
        pci_cyc_ack <= 1'b1;
        pci_rdata <= {pci_addr, ~pci_addr};
        cnt <= 4'h0;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* sim/pst_translator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pst_translator_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic proc_req_valid = 1'b0;
  logic proc_req_write = 1'b0;
  logic proc_req_quad = 1'b0;
  logic [39:0] proc_req_addr = 40'h00_0000_0000;
  logic [63:0] proc_req_wdata = 64'h0000_0000_0000_0000;
  logic [5:0] ext = 6'h2A;
  logic cfg_type_load = 1'b0;
  logic [1:0] cfg_type_wdata = 2'h0;
  logic fill_error_enable = 1'b1;
  logic [2:0] base1 = 3'h7;
  logic [5:0] base2 = 6'h00;
  logic [3:0] delay = 4'h0;
  logic proc_req_ready, proc_rsp_valid, proc_rsp_error, pci_cyc_valid, pci_cyc_ack;
  logic pci_neg_decode, pci_fill_check, sg_hit, sg_second_window;
  logic [63:0] proc_rsp_rdata, pci_wdata, pci_rdata;
  logic [3:0] pci_cmd, pci_be, pci_len;
  logic [31:0] pci_addr, exp_pa;
  logic [1:0] pci_cfg_type;
  logic [10:0] sg_index;
  int err_count = 0;
  int n_tests = 0;

  // free running clock
  always #5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  pst_translator i_dut
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .proc_req_valid(proc_req_valid),
    .proc_req_ready(proc_req_ready), .proc_req_write(proc_req_write),
    .proc_req_quad(proc_req_quad), .proc_req_addr(proc_req_addr),
    .proc_req_wdata(proc_req_wdata), .proc_rsp_valid(proc_rsp_valid),
    .proc_rsp_error(proc_rsp_error), .proc_rsp_rdata(proc_rsp_rdata),
    .memory_high_address_extension(ext), .cfg_type_load(cfg_type_load),
    .cfg_type_wdata(cfg_type_wdata), .fill_error_enable(fill_error_enable),
    .first_vme_window_base(base1), .second_vme_window_base(base2),
    .pci_cyc_valid(pci_cyc_valid), .pci_cyc_ack(pci_cyc_ack), .pci_cmd(pci_cmd),
    .pci_addr(pci_addr), .pci_be(pci_be), .pci_len(pci_len), .pci_cfg_type(pci_cfg_type),
    .pci_neg_decode(pci_neg_decode), .pci_fill_check(pci_fill_check),
    .pci_wdata(pci_wdata), .pci_rdata(pci_rdata), .sg_hit(sg_hit),
    .sg_second_window(sg_second_window), .sg_index(sg_index)
  );

  pst_pci_target i_tgt
  (
    .clk_sys(clk_sys), .pci_cyc_valid(pci_cyc_valid), .pci_addr(pci_addr),
    .pci_cyc_ack(pci_cyc_ack), .pci_rdata(pci_rdata), .delay(delay)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // offer a request, hold until taken, judge the kind of answer
  task automatic req(input logic wr, input logic q, input logic [39:0] a, input logic bad);
    int i;
    proc_req_write = wr;
    proc_req_quad = q;
    proc_req_addr = a;
    proc_req_wdata = {a[31:0], ~a[31:0]};
    proc_req_valid = 1'b1;
    i = 0;
    // ready is a state decode, so its settled value here holds at the next edge
    while (proc_req_ready !== 1'b1 && i < 40)
    begin
      @(negedge clk_sys);
      i++;
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    proc_req_valid = 1'b0;
    chk(proc_rsp_valid === bad && proc_rsp_error === bad && pci_cyc_valid === !bad, "kind");
    chk(proc_req_ready === bad, "ready after take");
    if (!bad)
      chk(pci_wdata === proc_req_wdata && pci_fill_check === fill_error_enable, "wdata");
    if (bad)
      @(negedge clk_sys);
  endtask

  task automatic fld(input logic [3:0] cmd, input logic [31:0] pa);
    exp_pa = pa;
    chk(pci_cmd === cmd && pci_addr === pa, "command or address");
  endtask

  // wait for the answer of a forwarded cycle
  task automatic done(input logic wr);
    int i;
    i = 0;
    while (proc_rsp_valid !== 1'b1 && i < 40)
    begin
      @(negedge clk_sys);
      i++;
    end
    chk(proc_rsp_valid === 1'b1 && proc_rsp_error === 1'b0, "no answer");
    if (!wr)
      chk(proc_rsp_rdata === {exp_pa, ~exp_pa}, "read data");
    @(negedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // every length code and quad, both high-bit regions
  task automatic t_smem;
    logic [39:0] a;
    logic [7:0] m;
    logic [3:0] n;
    logic [2:0] off;
    logic [1:0] c;
    logic [5:0] hi;
    logic q;
    for (int k = 0; k < 10; k++)
    begin
      q = (k % 5) == 4;
      c = q ? 2'h3 : 2'(k % 5);
      off = q ? 3'h0 : 3'((k % 5) * 3);
      a = 40'h80_0000_0000 | {(k > 4) ? 23'h07_2345 : 23'h03_2345, off, c, 3'h0};
      n = q ? 4'h8 : {2'h0, c} + 4'h1;
      m = ((8'h01 << n) - 8'h01) << off[1:0];
      hi = a[26] ? 6'h01 : ext;
      delay = 4'(k);
      req(k[0], q, a, 1'b0);
      fld(k[0] ? pst_pkg::CMD_MEM_WR : pst_pkg::CMD_MEM_RD, {hi, a[30:8], a[7:5]});
      chk(pci_be === (q ? 4'hF : m[3:0]) && pci_len === n && !pci_neg_decode, "len");
      done(k[0]);
    end
    a = 40'h80_07DF_FFF8;
    req(1'b0, 1'b0, a, 1'b0);
    fld(pst_pkg::CMD_MEM_RD, {6'h01, a[30:8], a[7:5]});
    done(1'b0);
  endtask

  // second window hit, then first window, then no hit
  task automatic t_vme;
    logic [39:0] a;
    a = 40'h80_0000_0000 | {23'h03_2345, 8'h00};
    ext = 6'h15;
    for (int j = 0; j < 3; j++)
    begin
      base2 = (j == 0) ? 6'h15 : 6'h3F;
      base1 = (j == 1) ? 3'h2 : 3'h7;
      req(1'b0, 1'b0, a, 1'b0);
      fld(pst_pkg::CMD_MEM_RD, {ext, a[30:8], a[7:5]});
      chk(sg_hit === 1'(j < 2) && sg_second_window === 1'(j == 0), "window");
      if (j < 2)
        chk(sg_index === ((j == 0) ? {3'h0, a[30:23]} : {ext[2:0], a[30:23]}), "idx");
      done(1'b0);
    end
    ext = 6'h2A;
    base1 = 3'h7;
    base2 = 6'h00;
  endtask

  task automatic t_sio;
    logic [39:0] a;
    for (int k = 0; k < 2; k++)
    begin
      a = k[0] ? 40'h85_80FF_FFF8 : 40'h85_80AB_CD68;
      req(k[0], 1'b0, a, 1'b0);
      fld(k[0] ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD, {7'h00, a[29:8], a[7:5]});
      chk(pci_neg_decode === 1'b1, "io claim");
      done(k[0]);
    end
    req(1'b0, 1'b0, 40'h85_8100_0000, 1'b1);
    req(1'b1, 1'b0, 40'h85_7FFF_FFF8, 1'b1);
  endtask

  task automatic ld(input logic [1:0] v);
    cfg_type_wdata = v;
    cfg_type_load = 1'b1;
    @(negedge clk_sys);
    cfg_type_load = 1'b0;
  endtask

  task automatic cfg(input logic wr, input logic [39:0] a, input logic [1:0] t);
    fld(wr ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD, {8'h00, a[28:8], a[7:5]});
    chk(pci_cfg_type === t, "config type");
    done(wr);
  endtask

  // probing with fill check off, selector changes and a reserved value
  task automatic t_cfg;
    fill_error_enable = 1'b0;
    ld(pst_pkg::CFG_TYPE1);
    req(1'b0, 1'b0, 40'h87_0002_0124, 1'b0);
    cfg(1'b0, 40'h87_0002_0124, pst_pkg::CFG_TYPE1);
    cfg_type_wdata = pst_pkg::CFG_TYPE0;
    cfg_type_load = 1'b1;
    req(1'b1, 1'b0, 40'h87_1FFF_FFF8, 1'b0);
    cfg_type_load = 1'b0;
    cfg(1'b1, 40'h87_1FFF_FFF8, pst_pkg::CFG_TYPE1);
    req(1'b1, 1'b0, 40'h87_0000_0008, 1'b0);
    cfg(1'b1, 40'h87_0000_0008, pst_pkg::CFG_TYPE0);
    ld(2'h2);
    req(1'b0, 1'b0, 40'h87_0000_0008, 1'b1);
    ld(pst_pkg::CFG_TYPE0);
    req(1'b0, 1'b0, 40'h87_2000_0000, 1'b1);
    fill_error_enable = 1'b1;
  endtask

  // addresses outside every space
  task automatic t_unm;
    req(1'b0, 1'b0, 40'h80_07E0_0000, 1'b1);
    req(1'b1, 1'b0, 40'h84_0000_0000, 1'b1);
    req(1'b0, 1'b0, 40'h7F_FFFF_FFF8, 1'b1);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_smem();
    t_vme();
    t_sio();
    t_cfg();
    t_unm();
    stop_test();
  end

  // cut a hang short
  initial
  begin
    #50000;
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
